// ==== hdl/mut_timer.sv ====
`timescale 1ns/1ps
`include "mut_defines.svh"

module mut_timer
  import mut_pkg::*;
#(
  parameter int AW     = 8,
  parameter int FS_DIV = `MUT_FS_DIV
)
(
  // Clock and reset.
  input  wire logic          i_clk,
  input  wire logic          i_rst_n,
  // Pin and power state.
  input  wire logic          i_counter_input_pin,
  input  wire logic          i_slow_mode,
  input  wire logic          i_stop_entry,
  // AXI4-Lite write channels.
  input  wire logic [AW-1:0] i_s_axi_awaddr,
  input  wire logic          i_s_axi_awvalid,
  output logic               o_s_axi_awready,
  input  wire logic [31:0]   i_s_axi_wdata,
  input  wire logic [3:0]    i_s_axi_wstrb,
  input  wire logic          i_s_axi_wvalid,
  output logic               o_s_axi_wready,
  output logic [1:0]         o_s_axi_bresp,
  output logic               o_s_axi_bvalid,
  input  wire logic          i_s_axi_bready,
  // AXI4-Lite read channels.
  input  wire logic [AW-1:0] i_s_axi_araddr,
  input  wire logic          i_s_axi_arvalid,
  output logic               o_s_axi_arready,
  output logic [31:0]        o_s_axi_rdata,
  output logic [1:0]         o_s_axi_rresp,
  output logic               o_s_axi_rvalid,
  input  wire logic          i_s_axi_rready,
  // Match request.
  output logic               o_match_interrupt
);

  localparam int FSW = $clog2(FS_DIV);

  mut_ctrl_t    counter_control_reg;
  logic [15:0]  compare_value_reg;
  logic [15:0]  capture_value_reg;
  logic [15:0]  count_reg;
  mut_state_t   state_reg;
  logic         irq_reg;
  logic [7:0]   cmp_lo_buf_reg;
  logic [7:0]   cmp_hi_buf_reg;
  logic         cmp_pend_reg;
  logic [10:0]  pres_reg;
  logic [FSW-1:0] fs_cnt_reg;
  logic [2:0]   fs8_reg;
  logic         awready_reg;
  logic         wready_reg;
  logic         bvalid_reg;
  logic [1:0]   bresp_reg;
  logic         arready_reg;
  logic         rvalid_reg;
  logic [31:0]  rdata_reg;
  logic [1:0]   rresp_reg;
  logic [AW-1:0] waddr_reg;
  logic [31:0]  wdata_reg;
  logic [3:0]   wstrb_reg;

  logic pin_level;
  logic pin_rise;
  logic pin_fall;

  // ---------------------------------------------------------------------------
  // Input pin conditioning.
  // ---------------------------------------------------------------------------
  mut_pin_filter #(
    .NF_LEN (`MUT_NF_LEN)
  ) u_filter (
    .i_clk    (i_clk),
    .i_rst_n  (i_rst_n),
    .i_pin    (i_counter_input_pin),
    .i_bypass (i_slow_mode),
    .o_level  (pin_level),
    .o_rise   (pin_rise),
    .o_fall   (pin_fall)
  );

  // ---------------------------------------------------------------------------
  // Prescaler.
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      pres_reg <= 11'h000;
    else
      pres_reg <= pres_reg + 11'h001;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      fs_cnt_reg <= '0;
      fs8_reg    <= 3'h0;
    end
    else if (fs_cnt_reg == FSW'(FS_DIV - 1))
    begin
      fs_cnt_reg <= '0;
      fs8_reg    <= fs8_reg + 3'h1;
    end
    else
      fs_cnt_reg <= fs_cnt_reg + FSW'(1);
  end

  logic fs_tick;
  assign fs_tick = (fs_cnt_reg == FSW'(FS_DIV - 1)) && (&fs8_reg);

  // ---------------------------------------------------------------------------
  // Mode decode.
  // ---------------------------------------------------------------------------
  mut_start_t start_f;
  logic       pin_clk;
  logic       is_timer;
  logic       is_ext;
  logic       is_event;
  logic       is_window;
  logic       active;
  logic       trig_edge;
  logic       opp_edge;
  logic       src_tick;
  logic       gate;
  logic       hit;
  logic [15:0] count_inc;

  assign start_f   = counter_control_reg.start_control_field;
  assign pin_clk   = counter_control_reg.source_clock_select == CLK_PIN;
  assign is_timer  = counter_control_reg.operating_mode_select == MODE_TIMER
                     && start_f == START_CMD && !pin_clk;
  assign is_ext    = counter_control_reg.operating_mode_select == MODE_TIMER
                     && start_f[1] && !pin_clk;
  assign is_event  = counter_control_reg.operating_mode_select == MODE_TIMER
                     && start_f[1] && pin_clk;
  assign is_window = counter_control_reg.operating_mode_select
                     == MODE_WINDOW && start_f[1] && !pin_clk;
  assign active    = is_timer || is_ext || is_event || is_window;
  assign trig_edge = (start_f == START_RISE) ? pin_rise : pin_fall;
  assign opp_edge  = (start_f == START_RISE) ? pin_fall : pin_rise;
  assign gate      = (start_f == START_RISE) ? pin_level : ~pin_level;
  assign count_inc = count_reg + 16'h0001;
  assign hit       = count_inc == compare_value_reg;

  // The low-frequency tap is the only one left once the fast clock stops.
  always_comb
  begin
    case (counter_control_reg.source_clock_select)
      CLK_SEL00:
        src_tick = (counter_control_reg.divider_tap_select || i_slow_mode)
                   ? fs_tick : (&pres_reg[`MUT_DIV_SEL00-1:0]);
      CLK_SEL01: src_tick = !i_slow_mode && (&pres_reg[`MUT_DIV_SEL01-1:0]);
      CLK_SEL10: src_tick = !i_slow_mode && (&pres_reg[`MUT_DIV_SEL10-1:0]);
      CLK_PIN:   src_tick = trig_edge;
      default:   src_tick = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------------------
  // Up-counter and sequencing.
  // ---------------------------------------------------------------------------
  // Mode and source are assumed steady while running.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      count_reg <= 16'h0000;
      state_reg <= S_IDLE;
      irq_reg   <= 1'b0;
    end
    else
    begin
      irq_reg <= 1'b0;
      if (!active)
      begin
        count_reg <= 16'h0000;
        state_reg <= S_IDLE;
      end
      else if (is_ext)
      begin
        case (state_reg)
          S_RUN:
          begin
            if (src_tick && hit)
            begin
              count_reg <= 16'h0000;
              state_reg <= S_WAIT;
              irq_reg   <= 1'b1;
            end
            else if (counter_control_reg.trigger_stop_select && opp_edge)
            begin
              count_reg <= 16'h0000;
              state_reg <= S_WAIT;
            end
            else if (src_tick)
              count_reg <= count_inc;
          end
          default:
          begin
            count_reg <= 16'h0000;
            state_reg <= trig_edge ? S_RUN : S_WAIT;
          end
        endcase
      end
      else if (is_event)
      begin
        state_reg <= S_RUN;
        if (trig_edge)
          count_reg <= count_inc;
        else if (opp_edge && count_reg == compare_value_reg)
        begin
          count_reg <= 16'h0000;
          irq_reg   <= 1'b1;
        end
      end
      else
      begin
        state_reg <= S_RUN;
        if (src_tick && (is_timer || gate))
        begin
          if (hit)
          begin
            count_reg <= 16'h0000;
            irq_reg   <= 1'b1;
          end
          else
            count_reg <= count_inc;
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Auto-capture.
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      capture_value_reg <= `MUT_CAPTURE_RST;
    else if (counter_control_reg.auto_capture_enable && src_tick
             && (is_timer || is_event || is_window))
      capture_value_reg <= count_reg;
  end

  // ---------------------------------------------------------------------------
  // Register writes.
  // ---------------------------------------------------------------------------
  logic wr_fire;
  logic wr_ctrl;
  logic wr_cmp;
  assign wr_fire = !awready_reg && !wready_reg && !bvalid_reg;
  assign wr_ctrl = wr_fire && waddr_reg == `MUT_OFS_CTRL;
  assign wr_cmp  = wr_fire && waddr_reg == `MUT_OFS_COMPARE;

  // Stop entry overrides a software write in the same cycle.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      counter_control_reg <= mut_ctrl_t'(`MUT_CTRL_RST);
    else
    begin
      if (wr_ctrl && wstrb_reg[0])
        counter_control_reg[7:0] <= wdata_reg[7:0];
      if (wr_ctrl && wstrb_reg[1])
        counter_control_reg[8] <= wdata_reg[8];
      if (i_stop_entry)
        counter_control_reg.start_control_field <= START_STOP;
    end
  end

  // The upper byte arms the compare value; it lands on the next tick, or on the next clock while stopped.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      cmp_lo_buf_reg    <= 8'h00;
      cmp_hi_buf_reg    <= 8'h00;
      cmp_pend_reg      <= 1'b0;
      compare_value_reg <= `MUT_COMPARE_RST;
    end
    else
    begin
      if (wr_cmp && wstrb_reg[0])
        cmp_lo_buf_reg <= wdata_reg[7:0];
      if (wr_cmp && wstrb_reg[1])
      begin
        cmp_hi_buf_reg <= wdata_reg[15:8];
        cmp_pend_reg   <= 1'b1;
      end
      else if (cmp_pend_reg && (src_tick || start_f == START_STOP))
      begin
        compare_value_reg <= {cmp_hi_buf_reg, cmp_lo_buf_reg};
        cmp_pend_reg      <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // AXI4-Lite write path.
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      awready_reg <= 1'b1;
      waddr_reg   <= '0;
    end
    else if (awready_reg && i_s_axi_awvalid)
    begin
      awready_reg <= 1'b0;
      waddr_reg   <= {i_s_axi_awaddr[AW-1:2], 2'b00};
    end
    else if (wr_fire)
      awready_reg <= 1'b1;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      wready_reg <= 1'b1;
      wdata_reg  <= 32'h0000_0000;
      wstrb_reg  <= 4'h0;
    end
    else if (wready_reg && i_s_axi_wvalid)
    begin
      wready_reg <= 1'b0;
      wdata_reg  <= i_s_axi_wdata;
      wstrb_reg  <= i_s_axi_wstrb;
    end
    else if (wr_fire)
      wready_reg <= 1'b1;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= `MUT_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= (waddr_reg[AW-1:4] == '0) ? `MUT_RESP_OKAY
                                              : `MUT_RESP_SLVERR;
    end
    else if (i_s_axi_bready)
      bvalid_reg <= 1'b0;
  end

  // ---------------------------------------------------------------------------
  // AXI4-Lite read path.
  // ---------------------------------------------------------------------------
  logic [AW-1:0] raddr;
  assign raddr = {i_s_axi_araddr[AW-1:2], 2'b00};

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= `MUT_RESP_OKAY;
    end
    else if (arready_reg && i_s_axi_arvalid)
    begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rresp_reg   <= `MUT_RESP_OKAY;
      case (raddr)
        `MUT_OFS_CTRL:    rdata_reg <= {23'h00_0000, counter_control_reg};
        `MUT_OFS_COMPARE: rdata_reg <= {16'h0000, compare_value_reg};
        `MUT_OFS_CAPTURE: rdata_reg <= {16'h0000, capture_value_reg};
        `MUT_OFS_COUNT:   rdata_reg <= {14'h0000, pin_level,
                                        state_reg == S_RUN, count_reg};
        default:
        begin
          rdata_reg <= 32'h0000_0000;
          rresp_reg <= `MUT_RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_reg && i_s_axi_rready)
    begin
      rvalid_reg  <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  assign o_s_axi_awready   = awready_reg;
  assign o_s_axi_wready    = wready_reg;
  assign o_s_axi_bvalid    = bvalid_reg;
  assign o_s_axi_bresp     = bresp_reg;
  assign o_s_axi_arready   = arready_reg;
  assign o_s_axi_rvalid    = rvalid_reg;
  assign o_s_axi_rdata     = rdata_reg;
  assign o_s_axi_rresp     = rresp_reg;
  assign o_match_interrupt = irq_reg;

  // ---------------------------------------------------------------------------
  // Checks.
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  AST_TIMER_WRAP: assert property (
    (is_timer && src_tick && hit && !i_stop_entry)
      |=> (count_reg == 16'h0000) && o_match_interrupt)
    else $error("Timer match did not clear and interrupt.");

  AST_CAPTURE_COPY: assert property (
    (counter_control_reg.auto_capture_enable && src_tick && is_timer)
      |=> capture_value_reg == $past(count_reg))
    else $error("Capture register missed the running count.");

  AST_CAPTURE_HOLD: assert property (
    !src_tick |=> $stable(capture_value_reg))
    else $error("Capture changed without a source tick.");

  AST_TRIG_START: assert property (
    (is_ext && state_reg != S_RUN && trig_edge && !i_stop_entry
     && !wr_ctrl)
      |=> (state_reg == S_RUN) && (count_reg == 16'h0000))
    else $error("Trigger edge did not start the counter.");

  AST_EXT_MATCH: assert property (
    (is_ext && state_reg == S_RUN && src_tick && hit && !wr_ctrl)
      |=> (state_reg == S_WAIT) && o_match_interrupt
       ##1 !o_match_interrupt)
    else $error("Triggered match did not halt with one interrupt.");

  AST_OPP_ABORT: assert property (
    (is_ext && state_reg == S_RUN && opp_edge && !(src_tick && hit)
     && counter_control_reg.trigger_stop_select && !wr_ctrl)
      |=> (state_reg == S_WAIT) && (count_reg == 16'h0000)
       && !o_match_interrupt)
    else $error("Opposite edge did not abort quietly.");

  AST_NO_STOP: assert property (
    (is_ext && state_reg == S_RUN && !src_tick
     && !counter_control_reg.trigger_stop_select && !wr_ctrl
     && !i_stop_entry)
      |=> (state_reg == S_RUN) && $stable(count_reg))
    else $error("Edge disturbed a run without trigger stop.");

  AST_EVENT_MATCH: assert property (
    o_match_interrupt && $past(is_event)
      |-> $past(opp_edge) && $past(count_reg == compare_value_reg))
    else $error("Event interrupt not at the opposite edge.");

  AST_WINDOW_GATE: assert property (
    (is_window && !gate && !wr_ctrl && !i_stop_entry)
      |=> $stable(count_reg))
    else $error("Window counted outside the gate.");

  AST_STOP_ENTRY: assert property (
    i_stop_entry |=> (start_f == START_STOP) [*2])
    else $error("Stop entry did not stop the counter.");

endmodule : mut_timer

// ==== hdl/mut_defines.svh ====
`ifndef MUT_DEFINES_SVH
`define MUT_DEFINES_SVH

// ---------------------------------------------------------------------------
// Register byte offsets.
// ---------------------------------------------------------------------------
`define MUT_OFS_CTRL      8'h00
`define MUT_OFS_COMPARE   8'h04
`define MUT_OFS_CAPTURE   8'h08
`define MUT_OFS_COUNT     8'h0C

// ---------------------------------------------------------------------------
// Field positions and reset values.
// ---------------------------------------------------------------------------
`define MUT_CTRL_W        9
`define MUT_CNT_RUN_BIT   16
`define MUT_CNT_PIN_BIT   17
`define MUT_CTRL_RST      9'h000
`define MUT_COMPARE_RST   16'hFFFF
`define MUT_CAPTURE_RST   16'h0000
`define MUT_RESP_OKAY     2'b00
`define MUT_RESP_SLVERR   2'b10

// ---------------------------------------------------------------------------
// Timing counts.
// ---------------------------------------------------------------------------
`define MUT_CLK_PER_FC    1
`define MUT_NF_REJECT_FC  4
`define MUT_NF_DETECT_FC  12
`define MUT_NF_LEN \
  (((`MUT_NF_REJECT_FC + `MUT_NF_DETECT_FC) / 2) * `MUT_CLK_PER_FC)
`define MUT_FS_DIV        512
`define MUT_DIV_SEL00     11
`define MUT_DIV_SEL01     7
`define MUT_DIV_SEL10     3
`define MUT_DIV_FS        3

`endif

// ==== hdl/mut_pkg.sv ====
package mut_pkg;

  typedef enum logic [1:0]
  {
    START_STOP = 2'b00,
    START_CMD  = 2'b01,
    START_RISE = 2'b10,
    START_FALL = 2'b11
  } mut_start_t;

  typedef enum logic [1:0]
  {
    CLK_SEL00 = 2'b00,
    CLK_SEL01 = 2'b01,
    CLK_SEL10 = 2'b10,
    CLK_PIN   = 2'b11
  } mut_clksel_t;

  typedef enum logic [1:0]
  {
    MODE_TIMER  = 2'b00,
    MODE_WINDOW = 2'b01,
    MODE_PWIDTH = 2'b10,
    MODE_PULSE  = 2'b11
  } mut_mode_t;

  typedef enum logic [1:0]
  {
    S_IDLE = 2'b00,
    S_WAIT = 2'b01,
    S_RUN  = 2'b10
  } mut_state_t;

  typedef struct packed
  {
    logic        divider_tap_select;
    logic        trigger_stop_select;
    logic        auto_capture_enable;
    mut_mode_t   operating_mode_select;
    mut_clksel_t source_clock_select;
    mut_start_t  start_control_field;
  } mut_ctrl_t;

endpackage : mut_pkg

// ==== hdl/mut_pin_filter.sv ====
`timescale 1ns/1ps
`include "mut_defines.svh"

module mut_pin_filter
  import mut_pkg::*;
#(
  parameter int NF_LEN = `MUT_NF_LEN
)
(
  // Clock and reset.
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // Pin and mode.
  input  wire logic i_pin,
  input  wire logic i_bypass,
  // Filtered level and edges.
  output logic      o_level,
  output logic      o_rise,
  output logic      o_fall
);

  localparam int CW = $clog2(NF_LEN) + 1;

  logic          sync_a_reg;
  logic          sync_b_reg;
  logic          level_reg;
  logic          level_d_reg;
  logic [CW-1:0] stable_cnt_reg;

  // ---------------------------------------------------------------------------
  // Synchroniser.
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      sync_a_reg <= 1'b0;
      sync_b_reg <= 1'b0;
    end
    else
    begin
      sync_a_reg <= i_pin;
      sync_b_reg <= sync_a_reg;
    end
  end

  // ---------------------------------------------------------------------------
  // Noise rejection.
  // ---------------------------------------------------------------------------
  // Unless bypassed, a new level is taken only after it has stood for NF_LEN clocks.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      level_reg      <= 1'b0;
      stable_cnt_reg <= '0;
    end
    else if (i_bypass)
    begin
      level_reg      <= sync_b_reg;
      stable_cnt_reg <= '0;
    end
    else if (sync_b_reg == level_reg)
      stable_cnt_reg <= '0;
    else if (stable_cnt_reg == CW'(NF_LEN - 1))
    begin
      level_reg      <= sync_b_reg;
      stable_cnt_reg <= '0;
    end
    else
      stable_cnt_reg <= stable_cnt_reg + CW'(1);
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      level_d_reg <= 1'b0;
    else
      level_d_reg <= level_reg;
  end

  assign o_level = level_reg;
  assign o_rise  = level_reg & ~level_d_reg;
  assign o_fall  = ~level_reg & level_d_reg;

  AST_NF_REJECT: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (!i_bypass && !$past(i_bypass) && $changed(level_reg))
      |-> ($past(sync_b_reg, 1) == level_reg)
       && ($past(sync_b_reg, 4) == level_reg)
       && ($past(sync_b_reg, 8) == level_reg))
    else $error("Filtered level changed after a short pulse.");

endmodule : mut_pin_filter

// ==== bench/mut_pulse_src.sv ====
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// External pulse source on the counter input pin.
// ---------------------------------------------------------------------------
module mut_pulse_src
(
  // Clock.
  input  wire logic i_clk,
  // Pin drive.
  output logic      o_pin
);
  initial o_pin = 1'b0;
  // Callers pass phases of 0 to 160 clocks, some highs shorter than the noise filter length.
  task automatic pulse(input int hi, input int lo);
    @(posedge i_clk);
    o_pin <= 1'b1;
    repeat (hi) @(posedge i_clk);
    o_pin <= 1'b0;
    repeat (lo) @(posedge i_clk);
  endtask : pulse
endmodule : mut_pulse_src

// ==== bench/multimode_up_counter_timer_tb.sv ====
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// Self-checking bench.
// ---------------------------------------------------------------------------
module multimode_up_counter_timer_tb
  import mut_pkg::*;
;
  logic        i_clk, i_rst_n, pin, stp, slw, awv, wv, bre, arv, rre;
  logic        awr, wrd, bv, arr, rv, irq;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rdt, d;
  logic [1:0]  bresp, rresp, r;
  int          error_cnt, total_checks, irqs, k, n;
  mut_timer #(.FS_DIV(4)) u_mut_timer (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_counter_input_pin(pin), .i_slow_mode(slw), .i_stop_entry(stp),
    .i_s_axi_awaddr(awa), .i_s_axi_awvalid(awv), .o_s_axi_awready(awr),
    .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wv),
    .o_s_axi_wready(wrd), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bv),
    .i_s_axi_bready(bre), .i_s_axi_araddr(ara), .i_s_axi_arvalid(arv),
    .o_s_axi_arready(arr), .o_s_axi_rdata(rdt), .o_s_axi_rresp(rresp),
    .o_s_axi_rvalid(rv), .i_s_axi_rready(rre), .o_match_interrupt(irq));
  mut_pulse_src u_mut_pulse_src (.i_clk(i_clk), .o_pin(pin));
  initial
  begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  always @(posedge i_clk) if (irq) irqs <= irqs + 1;
  task conclude;
    $display("errors %0d checks %0d", error_cnt, total_checks);
    if (error_cnt == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task to;
    error_cnt++;
    $display("[ERR] %0t wait ran out", $time);
    conclude();
  endtask : to
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_clk);
    awa <= a;
    wd  <= v;
    awv <= 1'b1;
    wv  <= 1'b1;
    bre <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge i_clk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
      if (bv) break;
    end
    r = bresp;
    bre <= 1'b0;
    if (n == 40) to();
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge i_clk);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge i_clk);
      if (arr) arv <= 1'b0;
      if (rv) break;
    end
    d = rdt;
    r = rresp;
    rre <= 1'b0;
    if (n == 40) to();
  endtask : rd
  task t_reset;
    rd(8'h04);
    chk(d, 32'h0000_FFFF);
    rd(8'h08);
    chk(d, 32'h0000_0000);
    rd(8'h10);
    chk(d, 32'h0000_0000);
    chk(r, 32'h0000_0002);
    wr(8'h10, 32'h0000_0001);
    chk(r, 32'h0000_0002);
  endtask : t_reset
  task t_timer;
    wr(8'h04, 32'h0000_0003);
    chk(r, 32'h0000_0000);
    wr(8'h00, 32'h0000_0049);
    for (n = 0; n < 300 && irq !== 1'b1; n++) @(posedge i_clk);
    if (n == 300) to();
    for (n = 1; n < 200; n++)
    begin
      @(posedge i_clk);
      if (irq) break;
    end
    if (n == 200) to();
    chk(n, 24);
    rd(8'h08);
    chk(d < 3, 1);
    @(posedge i_clk);
    stp <= 1'b1;
    @(posedge i_clk);
    stp <= 1'b0;
    k = irqs;
    rd(8'h00);
    chk(d, 32'h0000_0048);
    repeat (50) @(posedge i_clk);
    chk(irqs - k, 0);
  endtask : t_timer
  task t_event;
    wr(8'h00, 32'h0000_0000);
    wr(8'h04, 32'h0000_0002);
    wr(8'h00, 32'h0000_000E);
    k = irqs;
    u_mut_pulse_src.pulse(20, 20);
    u_mut_pulse_src.pulse(20, 0);
    chk(irqs - k, 0);
    repeat (20) @(posedge i_clk);
    chk(irqs - k, 1);
    u_mut_pulse_src.pulse(4, 20);
    rd(8'h0C);
    chk(d[15:0], 16'h0000);
    u_mut_pulse_src.pulse(12, 20);
    rd(8'h0C);
    chk(d[15:0], 16'h0001);
    slw <= 1'b1;
    @(posedge i_clk);
    k = irqs;
    u_mut_pulse_src.pulse(4, 20);
    rd(8'h0C);
    chk(d[15:0], 16'h0000);
    chk(irqs - k, 1);
    slw <= 1'b0;
  endtask : t_event
  task t_trig(input logic [31:0] c, input int hi, input int e);
    wr(8'h00, 32'h0000_0000);
    wr(8'h00, c);
    k = irqs;
    u_mut_pulse_src.pulse(hi, 150);
    u_mut_pulse_src.pulse(hi, 150);
    chk(irqs - k, e);
    rd(8'h0C);
    chk(d[15:0], 16'h0000);
  endtask : t_trig
  initial
  begin
    {i_rst_n, stp, slw, awv, wv, bre, arv, rre, awa, ara, wd} = '0;
    {error_cnt, total_checks, irqs} = '0;
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_reset();
    t_timer();
    t_event();
    wr(8'h04, 32'h0000_000A);
    t_trig(32'h0000_008A, 30, 0);
    t_trig(32'h0000_008A, 150, 2);
    t_trig(32'h0000_000A, 30, 2);
    t_trig(32'h0000_001A, 160, 4);
    conclude();
  end
endmodule : multimode_up_counter_timer_tb
